//--- rtl/fcdma_pkg.sv
// Register map, field layout and code constants of the four-channel DMA
package fcdma_pkg;
    localparam int NUM_CH = 4;
    // Byte offsets, channel block repeats every CH_STRIDE bytes
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFF_PRI = 8'h00;
    localparam logic [7:0] OFF_SEC = 8'h04;
    localparam logic [7:0] OFF_SRC = 8'h08;
    localparam logic [7:0] OFF_DST = 8'h0C;
    localparam logic [7:0] OFF_CNT = 8'h10;
    localparam logic [7:0] OFF_GCR_A = 8'h80;
    localparam logic [7:0] OFF_GCR_B = 8'h84;
    localparam logic [7:0] OFF_NDX_A = 8'h88;
    localparam logic [7:0] OFF_NDX_B = 8'h8C;
    localparam logic [7:0] OFF_GADDR_A = 8'h90;
    localparam logic [7:0] OFF_GADDR_B = 8'h94;
    localparam logic [7:0] OFF_GADDR_C = 8'h98;
    localparam logic [7:0] OFF_GADDR_D = 8'h9C;
    localparam logic [7:0] OFF_AUX = 8'hA0;
    // Primary control field positions
    localparam int RUN_POS = 0;
    localparam int STAT_POS = 2;
    localparam int SDIR_POS = 4;
    localparam int DDIR_POS = 6;
    localparam int ESZ_POS = 8;
    localparam int SPLIT_POS = 10;
    localparam int CRLD_POS = 12;
    localparam int NDX_POS = 13;
    localparam int READ_PACE_EVENT_POS = 14;
    localparam int WRITE_PACE_EVENT_POS = 19;
    localparam int PRI_POS = 24;
    localparam int TRANSFER_DONE_IRQ_EN_POS = 25;
    localparam int SRLD_POS = 28;
    localparam int DRLD_POS = 30;
    // Secondary control field positions
    localparam int SPLIT_F = 0;
    localparam int FRAME_F = 2;
    localparam int LAST_F = 4;
    localparam int BLOCK_F = 6;
    localparam int RDROP_F = 8;
    localparam int WDROP_F = 10;
    localparam int RPEND_POS = 12;
    localparam int RCLR_POS = 13;
    localparam int WPEND_POS = 14;
    localparam int WCLR_POS = 15;
    localparam int PIN_POS = 16;
    // Masks
    localparam logic [31:0] SEC_RW_MASK = 32'h0007_0AAA;
    localparam logic [31:0] SEC_FLAG_MASK = 32'h0000_0555;
    localparam logic [11:0] PAIR_MASK = 12'h555;
    localparam logic [31:0] GADDR_MASK = 32'hFFFF_FFF8;
    localparam logic [31:0] AUX_MASK = 32'h0000_001F;
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    // Run control codes
    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] RUN_START = 2'h1;
    localparam logic [1:0] RUN_PAUSE = 2'h2;
    localparam logic [1:0] RUN_AUTO = 2'h3;
    // Address update codes
    localparam logic [1:0] DIR_HOLD = 2'h0;
    localparam logic [1:0] DIR_INC = 2'h1;
    localparam logic [1:0] DIR_DEC = 2'h2;
    // Element width codes
    localparam logic [1:0] ESZ_32 = 2'h0;
    localparam logic [1:0] ESZ_16 = 2'h1;
    localparam logic [1:0] ESZ_8 = 2'h2;
    // Pacing event codes
    localparam logic [4:0] SYNC_NONE = 5'h00;
    localparam logic [4:0] SYNC_MAX = 5'h10;
    localparam int NUM_EVT = 17;
    // Channel pin codes
    localparam logic [2:0] PIN_LO = 3'h0;
    localparam logic [2:0] PIN_HI = 3'h1;
    localparam logic [2:0] PIN_RPEND = 3'h2;
    localparam logic [2:0] PIN_WPEND = 3'h3;
    localparam logic [2:0] PIN_FRAME = 3'h4;
    localparam logic [2:0] PIN_BLOCK = 3'h5;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/fcdma_core.sv
// Four-channel DMA controller: AXI4-Lite register file and element engine
// Summary of operation
// RL1: Four channels with five registers each, plus shared reload, index, address, aux.
// RL2: Run field bits 1:0: stop 0, start 1, pause 2, autoinit start 3.
// RL3: Direction fields at bits 4 and 6: hold, increment, decrement, indexed step.
// RL4: Five-bit read/write pacing selects at bits 14 and 19; 0 means unpaced.
// RL5: Element width field at bit 8: 32, 16 or 8 bits for codes 0-2.
// RL6: Primary holds split at 10, reload select 12, index select 13, 24, 25.
// RL7: Counter holds element count low half, frame count high half.
// RL8: Count reload registers hold element reload low, frame reload high.
// RL9: Index registers hold element step low, frame step high, for indexed mode.
// RL10: Shared address registers keep bits 31:3; low three bits read zero.
// RL11: Aux register holds four-bit channel rank at 0, rank bit at 4.
// RL12: Secondary bits 0-11 are six flag/enable pairs, flag on even bit.
// RL13: Secondary read/write pending at 12/14, their clears at 13/15, pin field 16.
// RL14: Pin field: low, high, read pending, write pending, frame flag, block flag.
// RL15: Split field 0 disables; 1-3 pick shared address A, B or C.
// RL16: Reload fields 0 none; 1-3 pick shared address B, C or D on autoinit.
// RL17: Priority bit 0 lets the CPU win, 1 lets the channel win; the bit only drives xfer_chan_first, the engine always wins.
// RL18: Channel interrupt asserts while any flag and its enable are both set.
// RL19: Element count counts down; at zero reload and count frames until block end.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module fcdma_core #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Element transfer request
    output logic xfer_valid,
    input wire logic xfer_ready,
    output logic [1:0] xfer_chan,
    output logic [31:0] xfer_src,
    output logic [31:0] xfer_dst,
    output logic [1:0] xfer_size,
    output logic xfer_chan_first,
    // Pacing events, asynchronous
    input wire logic [16:0] pace_evt,
    // Per-channel outputs
    output logic [3:0] chan_irq,
    output logic [3:0] chan_pin
);

    typedef struct packed {
        logic [31:0] pri;
        logic [31:0] sec;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] cnt;
    } fcdma_ch_t;

    typedef struct packed {
        fcdma_ch_t [fcdma_pkg::NUM_CH-1:0] ch;
        logic [1:0][31:0] gcr;
        logic [1:0][31:0] ndx;
        logic [3:0][31:0] gaddr;
        logic [31:0] aux;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic xv;
        logic [1:0] xchan;
        logic [31:0] xsrc;
        logic [31:0] xdst;
        logic [1:0] xsize;
        logic xpri;
        logic [16:0] s1;
        logic [16:0] s2;
        logic [16:0] s3;
        logic [16:0] filt;
    } fcdma_state_t;

    fcdma_state_t st_r;
    fcdma_state_t st_nxt;

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] b);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{b[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [31:0] m);
        return (o & ~m) | (d & m);
    endfunction

    // Address after one element
    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] dir,
                                         input logic [31:0] nb, input logic [15:0] ix);
        case (dir)
            fcdma_pkg::DIR_HOLD: step = a; // [RL3]
            fcdma_pkg::DIR_INC: step = a + nb; // [RL3]
            fcdma_pkg::DIR_DEC: step = a - nb; // [RL3]
            default: step = a + {{16{ix[15]}}, ix}; // [RL3] [RL9]
        endcase
    endfunction

    // Bytes per element; the reserved code moves words
    function automatic logic [31:0] elem_bytes(input logic [1:0] e);
        case (e)
            fcdma_pkg::ESZ_16: elem_bytes = 32'h0000_0002; // [RL5]
            fcdma_pkg::ESZ_8: elem_bytes = 32'h0000_0001; // [RL5]
            default: elem_bytes = 32'h0000_0004; // [RL5]
        endcase
    endfunction

    // Read mux, top bit says the address is mapped
    function automatic logic [32:0] rd_word(input fcdma_state_t s, input logic [7:0] a);
        logic [7:0] o;
        logic [1:0] c;
        logic [31:0] d;
        logic ok;
        o = a % fcdma_pkg::CH_STRIDE;
        c = 2'(a / fcdma_pkg::CH_STRIDE);
        d = '0;
        ok = 1'b1;
        if (a < fcdma_pkg::OFF_GCR_A) begin
            case (o)
                fcdma_pkg::OFF_PRI: begin
                    d = s.ch[c].pri;
                    d[fcdma_pkg::STAT_POS +: 2] = s.ch[c].pri[fcdma_pkg::RUN_POS +: 2];
                end
                fcdma_pkg::OFF_SEC: d = s.ch[c].sec;
                fcdma_pkg::OFF_SRC: d = s.ch[c].src;
                fcdma_pkg::OFF_DST: d = s.ch[c].dst;
                fcdma_pkg::OFF_CNT: d = s.ch[c].cnt;
                default: ok = 1'b0;
            endcase
        end else begin
            case (a)
                fcdma_pkg::OFF_GCR_A: d = s.gcr[0];
                fcdma_pkg::OFF_GCR_B: d = s.gcr[1];
                fcdma_pkg::OFF_NDX_A: d = s.ndx[0];
                fcdma_pkg::OFF_NDX_B: d = s.ndx[1];
                fcdma_pkg::OFF_GADDR_A: d = s.gaddr[0];
                fcdma_pkg::OFF_GADDR_B: d = s.gaddr[1];
                fcdma_pkg::OFF_GADDR_C: d = s.gaddr[2];
                fcdma_pkg::OFF_GADDR_D: d = s.gaddr[3];
                fcdma_pkg::OFF_AUX: d = s.aux;
                default: ok = 1'b0;
            endcase
        end
        return {ok, d};
    endfunction

    // Register write; flags are write-one-to-clear
    function automatic fcdma_state_t wr_word(input fcdma_state_t s, input logic [7:0] a,
                                             input logic [31:0] d, input logic [3:0] b,
                                             output logic ok);
        logic [7:0] o;
        logic [1:0] c;
        logic [31:0] m;
        logic [31:0] clr;
        logic [31:0] x;
        o = a % fcdma_pkg::CH_STRIDE;
        c = 2'(a / fcdma_pkg::CH_STRIDE);
        m = strb_mask(b);
        clr = d & m;
        ok = 1'b1;
        if (a < fcdma_pkg::OFF_GCR_A) begin
            x = s.ch[c].sec;
            case (o)
                fcdma_pkg::OFF_PRI: s.ch[c].pri = merge(s.ch[c].pri, d, m); // [RL2] [RL6]
                fcdma_pkg::OFF_SEC: begin
                    x = (x & ~fcdma_pkg::SEC_RW_MASK & ~(clr & fcdma_pkg::SEC_FLAG_MASK))
                        | (merge(x, d, m) & fcdma_pkg::SEC_RW_MASK); // [RL12]
                    if (clr[fcdma_pkg::RCLR_POS]) begin
                        x[fcdma_pkg::RPEND_POS] = 1'b0; // [RL13]
                    end
                    if (clr[fcdma_pkg::WCLR_POS]) begin
                        x[fcdma_pkg::WPEND_POS] = 1'b0; // [RL13]
                    end
                    s.ch[c].sec = x;
                end
                fcdma_pkg::OFF_SRC: s.ch[c].src = merge(s.ch[c].src, d, m);
                fcdma_pkg::OFF_DST: s.ch[c].dst = merge(s.ch[c].dst, d, m);
                fcdma_pkg::OFF_CNT: s.ch[c].cnt = merge(s.ch[c].cnt, d, m); // [RL7]
                default: ok = 1'b0;
            endcase
        end else begin
            case (a)
                fcdma_pkg::OFF_GCR_A: s.gcr[0] = merge(s.gcr[0], d, m); // [RL8]
                fcdma_pkg::OFF_GCR_B: s.gcr[1] = merge(s.gcr[1], d, m); // [RL8]
                fcdma_pkg::OFF_NDX_A: s.ndx[0] = merge(s.ndx[0], d, m); // [RL9]
                fcdma_pkg::OFF_NDX_B: s.ndx[1] = merge(s.ndx[1], d, m); // [RL9]
                fcdma_pkg::OFF_GADDR_A, fcdma_pkg::OFF_GADDR_B,
                fcdma_pkg::OFF_GADDR_C, fcdma_pkg::OFF_GADDR_D: begin
                    x = merge(s.gaddr[a[3:2]], d, m);
                    s.gaddr[a[3:2]] = x & fcdma_pkg::GADDR_MASK; // [RL10]
                end
                fcdma_pkg::OFF_AUX: s.aux = merge(s.aux, d, m) & fcdma_pkg::AUX_MASK; // [RL11]
                default: ok = 1'b0;
            endcase
        end
        return s;
    endfunction

    // Handshake outputs straight from state; one write and one read at a time
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;

    logic wr_ok;
    logic [32:0] rd_res;
    logic [16:0] agree;
    logic [16:0] rise;
    logic found;
    logic [1:0] k;
    logic [31:0] p;
    logic [31:0] cn;
    logic [31:0] cn_n;
    logic [31:0] sc;
    logic [31:0] gr;
    logic [31:0] ix;
    logic [31:0] nb;
    logic [31:0] ns;
    logic [31:0] nd;
    logic [31:0] ga;
    logic [1:0] sp;
    logic [1:0] run;
    logic [4:0] rs;
    logic [4:0] ws;
    logic fe;
    logic be;

    // Next-state: bus, then engine, then pacing events (sets win over clears)
    always_comb begin
        st_nxt = st_r;
        wr_ok = 1'b0;
        rd_res = '0;
        found = 1'b0;
        k = st_r.xchan;
        p = '0;
        cn = '0;
        cn_n = '0;
        sc = '0;
        gr = '0;
        ix = '0;
        nb = '0;
        ns = '0;
        nd = '0;
        ga = '0;
        sp = '0;
        run = '0;
        rs = '0;
        ws = '0;
        fe = 1'b0;
        be = 1'b0;

        // Pin synchroniser: a level counts once the second and third stages agree
        st_nxt.s1 = pace_evt;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        agree = ~(st_r.s2 ^ st_r.s3);
        st_nxt.filt = (st_r.s3 & agree) | (st_r.filt & ~agree);
        rise = st_r.s3 & agree & ~st_r.filt;

        // Write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt = wr_word(st_nxt, st_r.awaddr, st_r.wdata, st_r.wstrb, wr_ok); // [RL1]
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_ok ? fcdma_pkg::RESP_OKAY : fcdma_pkg::RESP_SLVERR;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read data registered one cycle after the address is taken
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd_res = rd_word(st_r, 8'(s_axi_araddr)); // [RL1]
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_res[31:0];
            st_nxt.rresp = rd_res[32] ? fcdma_pkg::RESP_OKAY : fcdma_pkg::RESP_SLVERR;
        end

        // Element done: step addresses and counters; engine overrides a same-cycle write to source, destination or count
        if (st_r.xv && xfer_ready) begin
            st_nxt.xv = 1'b0;
            p = st_r.ch[k].pri;
            cn = st_r.ch[k].cnt;
            sc = st_nxt.ch[k].sec;
            run = p[fcdma_pkg::RUN_POS +: 2];
            nb = elem_bytes(st_r.xsize);
            gr = st_r.gcr[p[fcdma_pkg::CRLD_POS]]; // [RL6] [RL8]
            ix = st_r.ndx[p[fcdma_pkg::NDX_POS]]; // [RL6] [RL9]
            fe = cn[15:0] <= 16'h0001; // [RL7]
            be = fe && (cn[31:16] <= 16'h0001);
            ns = step(st_r.xsrc, p[fcdma_pkg::SDIR_POS +: 2], nb, fe ? ix[31:16] : ix[15:0]);
            nd = step(st_r.xdst, p[fcdma_pkg::DDIR_POS +: 2], nb, fe ? ix[31:16] : ix[15:0]);
            if (!fe) begin
                cn_n = {cn[31:16], cn[15:0] - 16'h0001}; // [RL19]
            end else if (!be) begin
                cn_n = {cn[31:16] - 16'h0001, gr[15:0]}; // [RL19]
                sc[fcdma_pkg::FRAME_F] = 1'b1;
                if (cn[31:16] - 16'h0001 == 16'h0001) begin
                    sc[fcdma_pkg::LAST_F] = 1'b1;
                end
            end else begin
                sc[fcdma_pkg::BLOCK_F] = 1'b1;
                if (run == fcdma_pkg::RUN_AUTO) begin
                    cn_n = gr; // [RL2] [RL19]
                    if (p[fcdma_pkg::SRLD_POS +: 2] != 2'h0) begin
                        ns = st_r.gaddr[p[fcdma_pkg::SRLD_POS +: 2]]; // [RL16]
                    end
                    if (p[fcdma_pkg::DRLD_POS +: 2] != 2'h0) begin
                        nd = st_r.gaddr[p[fcdma_pkg::DRLD_POS +: 2]]; // [RL16]
                    end
                end else begin
                    cn_n = '0;
                    st_nxt.ch[k].pri[fcdma_pkg::RUN_POS +: 2] = fcdma_pkg::RUN_STOP; // [RL2]
                end
            end
            // Split flag when the element touched the selected split address
            sp = p[fcdma_pkg::SPLIT_POS +: 2];
            if (sp != 2'h0) begin
                ga = st_r.gaddr[2'(sp - 2'h1)]; // [RL15]
                if (st_r.xsrc[31:3] == ga[31:3] || st_r.xdst[31:3] == ga[31:3]) begin
                    sc[fcdma_pkg::SPLIT_F] = 1'b1;
                end
            end
            st_nxt.ch[k].sec = sc;
            st_nxt.ch[k].src = ns;
            st_nxt.ch[k].dst = nd;
            st_nxt.ch[k].cnt = cn_n;
        end

        // Issue: lowest ready channel wins; stop and pause hold the channel
        for (int i = 0; i < fcdma_pkg::NUM_CH; i++) begin
            rs = st_r.ch[i].pri[fcdma_pkg::READ_PACE_EVENT_POS +: 5]; // [RL4]
            ws = st_r.ch[i].pri[fcdma_pkg::WRITE_PACE_EVENT_POS +: 5]; // [RL4]
            run = st_r.ch[i].pri[fcdma_pkg::RUN_POS +: 2];
            if (!st_r.xv && !found
                && (run == fcdma_pkg::RUN_START || run == fcdma_pkg::RUN_AUTO) // [RL2]
                && (rs == fcdma_pkg::SYNC_NONE || st_r.ch[i].sec[fcdma_pkg::RPEND_POS])
                && (ws == fcdma_pkg::SYNC_NONE || st_r.ch[i].sec[fcdma_pkg::WPEND_POS])) begin
                found = 1'b1;
                st_nxt.xv = 1'b1;
                st_nxt.xchan = 2'(i);
                st_nxt.xsrc = st_r.ch[i].src;
                st_nxt.xdst = st_r.ch[i].dst;
                st_nxt.xsize = st_r.ch[i].pri[fcdma_pkg::ESZ_POS +: 2]; // [RL5]
                st_nxt.xpri = st_r.ch[i].pri[fcdma_pkg::PRI_POS]; // [RL17]
                st_nxt.ch[i].sec[fcdma_pkg::RPEND_POS] = 1'b0;
                st_nxt.ch[i].sec[fcdma_pkg::WPEND_POS] = 1'b0;
            end
            // An event on a still-pending request is a drop
            if (rs != fcdma_pkg::SYNC_NONE && rs <= fcdma_pkg::SYNC_MAX && rise[rs]) begin
                if (st_nxt.ch[i].sec[fcdma_pkg::RPEND_POS]) begin
                    st_nxt.ch[i].sec[fcdma_pkg::RDROP_F] = 1'b1; // [RL12]
                end
                st_nxt.ch[i].sec[fcdma_pkg::RPEND_POS] = 1'b1; // [RL4] [RL13]
            end
            if (ws != fcdma_pkg::SYNC_NONE && ws <= fcdma_pkg::SYNC_MAX && rise[ws]) begin
                if (st_nxt.ch[i].sec[fcdma_pkg::WPEND_POS]) begin
                    st_nxt.ch[i].sec[fcdma_pkg::WDROP_F] = 1'b1; // [RL12]
                end
                st_nxt.ch[i].sec[fcdma_pkg::WPEND_POS] = 1'b1; // [RL4] [RL13]
            end
        end
    end

    // State register, synchronous reset clears everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Registered data outputs
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign xfer_valid = st_r.xv;
    assign xfer_chan = st_r.xchan;
    assign xfer_src = st_r.xsrc;
    assign xfer_dst = st_r.xdst;
    assign xfer_size = st_r.xsize;
    assign xfer_chan_first = st_r.xpri;

    // Per-channel interrupt and pin, decoded from registered secondary control
    for (genvar g = 0; g < fcdma_pkg::NUM_CH; g++) begin : g_ch
        logic [31:0] scg;
        logic pin_v;
        assign scg = st_r.ch[g].sec;
        assign chan_irq[g] = |(scg[11:0] & (scg[11:0] >> 1) & fcdma_pkg::PAIR_MASK); // [RL18]
        always_comb begin
            case (scg[fcdma_pkg::PIN_POS +: 3])
                fcdma_pkg::PIN_LO: pin_v = 1'b0; // [RL14]
                fcdma_pkg::PIN_HI: pin_v = 1'b1; // [RL14]
                fcdma_pkg::PIN_RPEND: pin_v = scg[fcdma_pkg::RPEND_POS]; // [RL14]
                fcdma_pkg::PIN_WPEND: pin_v = scg[fcdma_pkg::WPEND_POS]; // [RL14]
                fcdma_pkg::PIN_FRAME: pin_v = scg[fcdma_pkg::FRAME_F]; // [RL14]
                fcdma_pkg::PIN_BLOCK: pin_v = scg[fcdma_pkg::BLOCK_F]; // [RL14]
                default: pin_v = 1'b0;
            endcase
        end
        assign chan_pin[g] = pin_v;
    end

endmodule

//--- verification/fcdma_properties.sv
// Checker for the register bus and element request ports
`timescale 1ns/10ps
module fcdma_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Element requests
    input wire logic xfer_valid,
    input wire logic xfer_ready,
    input wire logic [31:0] xfer_src,
    input wire logic [1:0] xfer_size
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken at one edge
    sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_xfer_wait; xfer_valid && !xfer_ready; endsequence
    a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("bvalid late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    a_xfer_hold: assert property (s_xfer_wait |=> xfer_valid && $stable(xfer_src))
        else $error("request moved");
    a_xfer_gap: assert property (xfer_valid && xfer_ready |=> !xfer_valid)
        else $error("request too soon");
    a_size_code: assert property (xfer_valid |-> xfer_size != 2'h3)
        else $error("bad size");
endmodule
bind fcdma_core fcdma_props u_props (.*);

//--- verification/fcdma_mem_model.sv
// Memory side: completes each element after a random stall
`timescale 1ns/10ps
module fcdma_mem_model (
    // Clock
    input wire logic aclk,
    // Element handshake
    input wire logic xfer_valid,
    output logic xfer_ready
);
    // Ready pulses one cycle, so no element is ever taken twice
    always @(posedge aclk) begin
        xfer_ready <= xfer_valid === 1'b1 && xfer_ready !== 1'b1 && $urandom_range(0, 2) == 0;
    end
endmodule

//--- verification/fcdma_tb_top.sv
// Bench for the register map and element engine of the DMA
`timescale 1ns/10ps
module fcdma_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [16:0] pace_evt = 17'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic xfer_valid, xfer_ready, xfer_chan_first;
    logic [1:0] s_axi_bresp, s_axi_rresp, xfer_chan, xfer_size;
    logic [31:0] s_axi_rdata, xfer_src, xfer_dst;
    logic [3:0] chan_irq, chan_pin;
    int n_mismatch = 0, total_checks = 0, n_el = 0, esz = 0, nel = 0, ev = 0;
    always #25 aclk = ~aclk;
    fcdma_core dut (.*);
    fcdma_mem_model u_mem (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // Address step of one element in bytes
    function automatic logic [31:0] step(input int sz);
        return 32'h4 >> sz;
    endfunction
    // Bus write; each channel released only once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge aclk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Source climbs and destination falls by one element each move
    always @(posedge aclk) begin
        if (xfer_valid && xfer_ready) begin
            chk("src", 32'h100 + 32'(n_el) * step(esz), xfer_src);
            chk("dst", 32'h400 - 32'(n_el) * step(esz), xfer_dst);
            chk("size", 32'(esz), {30'h0, xfer_size});
            chk("chan", 32'h0, {30'h0, xfer_chan});
            chk("first", 32'(n_el >= 2 * nel), {31'h0, xfer_chan_first});
            n_el++;
        end
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'hBCA1EBDE));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h80, 32'h0, 2'h0);
        wr(8'h90, 32'hFFFF_FFFF, 2'h0);
        rd(8'h90, 32'hFFFF_FFF8, 2'h0);
        wr(8'hA0, 32'hFFFF_FFFF, 2'h0);
        rd(8'hA0, 32'h0000_001F, 2'h0);
        wr(8'h24, 32'hFFF9_FFFF, 2'h0);
        rd(8'h24, 32'h0001_0AAA, 2'h0);
        wr(8'hFC, 32'h1, 2'h2);
        rd(8'hFC, 32'h0, 2'h2);
        esz = $urandom_range(0, 2);
        nel = $urandom_range(2, 5);
        wr(8'h80, 32'(nel), 2'h0);
        wr(8'h08, 32'h100, 2'h0);
        wr(8'h0C, 32'h400, 2'h0);
        wr(8'h10, {16'h2, 16'(nel)}, 2'h0);
        wr(8'h04, 32'h0005_0080, 2'h0);
        wr(8'h00, {22'h0, 2'(esz), 8'h91}, 2'h0);
        for (int i = 0; i < 400 && n_el < 2 * nel; i++) @(posedge aclk);
        repeat (6) @(posedge aclk);
        chk("moves", 32'(2 * nel), 32'(n_el));
        rd(8'h10, 32'h0, 2'h0);
        rd(8'h00, {22'h0, 2'(esz), 8'h90}, 2'h0);
        rd(8'h04, 32'h0005_00D4, 2'h0);
        chk("irq", 32'h1, {28'h0, chan_irq});
        chk("pin", 32'h3, {28'h0, chan_pin});
        wr(8'h04, 32'h0005_00D4, 2'h0);
        chk("irq", 32'h0, {28'h0, chan_irq});
        chk("pin", 32'h2, {28'h0, chan_pin});
        ev = $urandom_range(1, 16);
        wr(8'h00, {7'h0, 1'b1, 5'h0, 5'(ev), 4'h0, 2'(esz), 8'h91}, 2'h0);
        repeat (20) @(posedge aclk);
        chk("unpaced", 32'(2 * nel), 32'(n_el));
        pace_evt <= 17'h1 << ev;
        for (int i = 0; i < 200 && n_el <= 2 * nel; i++) @(posedge aclk);
        chk("paced", 32'(2 * nel + 1), 32'(n_el));
        rd(8'h08, 32'h100 + 32'(2 * nel + 1) * step(esz), 2'h0);
        results();
    end
endmodule
